// ==== ahb_host.sv ====
`timescale 1ns/1ns
`default_nettype none

// Host model: one single word transfer at a time
module ahb_host (
    // Clock and bus answer
    input wire logic sys_clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    // Bus request
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    // Idle bus from time zero
    initial begin
        hsel_out = 1'h0;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'h0;
        hsize_out = 3'h0;
        hwdata_out = 32'h0;
    end

    // Address phase held until ready, then data phase held until ready
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        logic [31:0] v;
        v = d;
        if (a[7:2] == rate_ref_pkg::IDX_RATE) v[7:4] = {1'h0, v[6:5], 1'h1};
        if (a[7:2] == rate_ref_pkg::IDX_REF) v[7] = 1'h0;
        @(posedge sys_clk_in);
        hsel_out <= 1'h1;
        haddr_out <= a;
        htrans_out <= 2'h2;
        hwrite_out <= wr;
        hsize_out <= rate_ref_pkg::HSIZE_WORD;
        do @(posedge sys_clk_in); while (hready_in !== 1'h1);
        hsel_out <= 1'h0;
        htrans_out <= 2'h0;
        hwdata_out <= v;
        do @(posedge sys_clk_in); while (hready_in !== 1'h1);
        q = hrdata_in;
    endtask : xfer
endmodule : ahb_host

`default_nettype wire

// ==== level_sync3.sv ====
`timescale 1ns/1ns
`default_nettype none

// Three-stage synchroniser; the output follows once stages two and three agree
module level_sync3 (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // Asynchronous level and its filtered copy
    input wire logic async_in,
    output logic level_out
);

    typedef struct packed {
        logic meta;
        logic mid;
        logic last;
        logic level;
    } sync_t;

    sync_t sync_reg;
    sync_t sync_next;

    // First stage feeds only the second, so metastability never reaches logic
    always_comb begin
        sync_next = sync_reg;
        sync_next.meta = async_in;
        sync_next.mid = sync_reg.meta;
        sync_next.last = sync_reg.mid;
        if (sync_reg.mid == sync_reg.last) begin
            sync_next.level = sync_reg.last; // One-cycle glitches are rejected
        end
    end

    // All stages clear on reset, so the level starts low
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_reg <= 4'h0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    // Filtered level straight from its flip-flop
    assign level_out = sync_reg.level;

endmodule : level_sync3
`default_nettype wire

// ==== rate_ref_config.sv ====
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Rate register at index 04h, resets to 14h, every bit read and write.
// - Rate bit 6 picks clock: 0 internal oscillator, 1 external clock.
// - Rate bit 5 picks mode: 0 continuous, 1 single-shot conversions.
// - Rate code bits 3:0 reset to 0100 (20 SPS); code 1111 reserved.
// - Reference control register at index 05h, resets to 10h, read and write.
// - Reference bit 6 enables the external reference monitor; resets disabled.
// - Enabled monitor sets read-only low flag while reference under 0.3 V.
module rate_ref_config (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Reference comparator, asynchronous, high while reference under 0.3 V
    input wire logic ref_below_thresh_in,
    // Conversion configuration
    output logic clock_ext_sel_out,
    output logic single_shot_out,
    output logic [3:0] rate_code_out,
    output logic [15:0] rate_dsps_out,
    output logic rate_reserved_out,
    // Reference configuration and monitor
    output logic ext_ref_monitor_enable_out,
    output logic [5:0] ref_fields_out,
    output logic ext_ref_low_flag_out
);

    typedef struct packed {
        logic [7:0] rate;
        logic [7:0] refc;
        logic [15:0] rate_dsps;
        logic low_flag;
        logic pend_wr;
        logic [5:0] pend_idx;
        logic [7:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic below_level;
    logic addr_phase;
    logic [5:0] addr_idx;
    logic addr_in_window;

    // Comparator level crosses into the clock domain
    level_sync3 ref_sync (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .async_in(ref_below_thresh_in),
        .level_out(below_level)
    );

    // Address phase decode; only the low 256 bytes hold registers
    assign addr_phase = hsel_in & htrans_in[1] & hready_in;
    assign addr_idx = haddr_in[rate_ref_pkg::HADDR_IDX_LSB +: 6];
    assign addr_in_window = (haddr_in[31:8] == 24'h000000);

    // Next state: data-phase write first, then read data from the new values
    always_comb begin
        state_next = state_reg;
        if (state_reg.pend_wr) begin
            unique case (state_reg.pend_idx)
                rate_ref_pkg::IDX_RATE: begin
                    state_next.rate = hwdata_in[7:0];
                end
                rate_ref_pkg::IDX_REF: begin
                    state_next.refc = hwdata_in[7:0];
                end
                default: begin
                    // Status is read-only; other indices ignore writes
                end
            endcase
        end
        state_next.rate_dsps = rate_ref_pkg::RATE_DSPS_TABLE[state_next.rate[3:0]];
        state_next.low_flag = state_next.refc[rate_ref_pkg::REF_MON_BIT] & below_level;
        // Capture the request; a read gets data now so it stands in the data phase
        state_next.pend_wr = addr_phase & hwrite_in & addr_in_window
            & (hsize_in == rate_ref_pkg::HSIZE_WORD);
        state_next.pend_idx = addr_idx;
        if (addr_phase & ~hwrite_in) begin
            state_next.rdata = 8'h00;
            if (addr_in_window) begin
                unique case (addr_idx)
                    rate_ref_pkg::IDX_STATUS: begin
                        state_next.rdata[rate_ref_pkg::STATUS_FLAG_BIT] = state_next.low_flag;
                    end
                    rate_ref_pkg::IDX_RATE: begin
                        state_next.rdata = state_next.rate;
                    end
                    rate_ref_pkg::IDX_REF: begin
                        state_next.rdata = state_next.refc;
                    end
                    default: begin
                        state_next.rdata = 8'h00;
                    end
                endcase
            end
        end
    end

    // State register; reset loads the documented values
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg.rate <= rate_ref_pkg::RATE_RESET;
            state_reg.refc <= rate_ref_pkg::REF_RESET;
            state_reg.rate_dsps <= rate_ref_pkg::RATE_DSPS_RESET;
            state_reg.low_flag <= 1'h0;
            state_reg.pend_wr <= 1'h0;
            state_reg.pend_idx <= 6'h00;
            state_reg.rdata <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus answers: zero wait states, always OKAY
    assign hreadyout_out = 1'h1;
    assign hresp_out = 1'h0;
    assign hrdata_out = {24'h000000, state_reg.rdata};

    // Configuration outputs straight from register fields, except the reserved-code flag, which is a compare
    // clock source select
    assign clock_ext_sel_out = state_reg.rate[rate_ref_pkg::RATE_CLK_BIT];
    assign single_shot_out = state_reg.rate[rate_ref_pkg::RATE_MODE_BIT];
    assign rate_code_out = state_reg.rate[rate_ref_pkg::RATE_CODE_LSB +: 4];
    assign rate_dsps_out = state_reg.rate_dsps;
    // reserved code flagged; reserved bits are stored as written
    assign rate_reserved_out = (state_reg.rate[3:0] == rate_ref_pkg::RATE_CODE_RESERVED);
    assign ext_ref_monitor_enable_out = state_reg.refc[rate_ref_pkg::REF_MON_BIT];
    assign ref_fields_out = state_reg.refc[5:0];
    assign ext_ref_low_flag_out = state_reg.low_flag;

    // Write to the rate register lands one cycle after its data phase
    // rate write lands
    a_rate_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        state_reg.pend_wr && state_reg.pend_idx == rate_ref_pkg::IDX_RATE
        |=> rate_code_out == $past(hwdata_in[3:0]) && hrdata_out[31:8] == 24'h000000)
        else $error("rate write lost");

    a_rate_reset: assert property (@(posedge sys_clk_in)
        !$past(resetn_in) && resetn_in |-> state_reg.rate == rate_ref_pkg::RATE_RESET)
        else $error("rate reset value wrong");

    a_rate_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !(state_reg.pend_wr && state_reg.pend_idx == rate_ref_pkg::IDX_RATE)
        |=> $stable(state_reg.rate))
        else $error("rate changed without write");

    a_rate_read: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        addr_phase && !hwrite_in && addr_in_window && addr_idx == rate_ref_pkg::IDX_RATE
        |=> hrdata_out == {24'h000000, state_reg.rate})
        else $error("rate read wrong");

    a_clock_select: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        state_reg.pend_wr && state_reg.pend_idx == rate_ref_pkg::IDX_RATE
        |=> clock_ext_sel_out == $past(hwdata_in[6]))
        else $error("clock select wrong");

    a_mode_select: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        state_reg.pend_wr && state_reg.pend_idx == rate_ref_pkg::IDX_RATE
        |=> single_shot_out == $past(hwdata_in[5]))
        else $error("mode select wrong");

    a_rate_default: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (rate_code_out == 4'h4 |-> rate_dsps_out == 16'h00c8)
        and (rate_code_out == 4'hf |-> rate_reserved_out && rate_dsps_out == 16'h0000))
        else $error("rate code decode wrong");

    a_rate_ends: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (rate_code_out == 4'h0 |-> rate_dsps_out == 16'h0019)
        and (rate_code_out == 4'he |-> rate_dsps_out == 16'h9c40))
        else $error("rate extremes wrong");

    a_ref_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (!$past(resetn_in) |-> state_reg.refc == rate_ref_pkg::REF_RESET)
        and (state_reg.pend_wr && state_reg.pend_idx == rate_ref_pkg::IDX_REF
            |=> state_reg.refc == $past(hwdata_in[7:0])))
        else $error("reference register wrong");

    a_ref_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !(state_reg.pend_wr && state_reg.pend_idx == rate_ref_pkg::IDX_REF)
        |=> $stable(state_reg.refc))
        else $error("reference changed without write");

    a_ref_read: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        addr_phase && !hwrite_in && addr_in_window && addr_idx == rate_ref_pkg::IDX_REF
        |=> hrdata_out == {24'h000000, state_reg.refc})
        else $error("reference read wrong");

    a_monitor_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        state_reg.pend_wr && state_reg.pend_idx == rate_ref_pkg::IDX_REF
        |=> ext_ref_monitor_enable_out == $past(hwdata_in[6]))
        else $error("monitor enable write lost");

    a_monitor_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !ext_ref_monitor_enable_out |-> !ext_ref_low_flag_out)
        else $error("flag set while monitor off");

    a_low_flag: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        ext_ref_monitor_enable_out && $past(resetn_in)
        |-> ext_ref_low_flag_out == $past(below_level))
        else $error("low flag wrong");

    a_status_read: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        addr_phase && !hwrite_in && addr_in_window && addr_idx == rate_ref_pkg::IDX_STATUS
        |=> hrdata_out == {31'h00000000, ext_ref_low_flag_out})
        else $error("status read wrong");

endmodule : rate_ref_config
`default_nettype wire

// ==== rate_ref_pkg.sv ====
package rate_ref_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_RATE = 6'h04;
    localparam logic [5:0] IDX_REF = 6'h05;

    // Values after reset
    localparam logic [7:0] RATE_RESET = 8'h14;
    localparam logic [7:0] REF_RESET = 8'h10;
    localparam logic [15:0] RATE_DSPS_RESET = 16'h00c8;

    // Field positions
    localparam int RATE_CLK_BIT = 6;
    localparam int RATE_MODE_BIT = 5;
    localparam int RATE_CODE_LSB = 0;
    localparam int REF_MON_BIT = 6;
    localparam int STATUS_FLAG_BIT = 0;

    // Rate code of the reserved setting
    localparam logic [3:0] RATE_CODE_RESERVED = 4'hf;

    // AHB constants
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int HADDR_IDX_LSB = 2;

    // Output data rate in tenths of a sample per second, by rate code
    localparam logic [15:0] RATE_DSPS_TABLE [16] = '{
        16'h0019, 16'h0032, 16'h0064, 16'h00a6,
        16'h00c8, 16'h01f4, 16'h0258, 16'h03e8,
        16'h07d0, 16'h0fa0, 16'h1f40, 16'h2710,
        16'h4e20, 16'h9c40, 16'h9c40, 16'h0000
    };

endpackage : rate_ref_pkg

// ==== testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic sys_clk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic ref_below = 1'h0;
    logic hsel, hwrite, hready, cext, sshot, rres, mon_en, low_flag, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [3:0] code, cb;
    logic [15:0] dsps;
    logic [5:0] ref_fields;
    int failures = 0;
    int comparisons = 0;
    localparam logic [31:0] RATE_A = {24'h0, rate_ref_pkg::IDX_RATE, 2'h0};
    localparam logic [31:0] REF_A = {24'h0, rate_ref_pkg::IDX_REF, 2'h0};
    localparam logic [31:0] STAT_A = {24'h0, rate_ref_pkg::IDX_STATUS, 2'h0};
    // Expected rate in tenths of a sample per second, by code
    localparam logic [15:0] RATES [15] = '{16'h0019, 16'h0032, 16'h0064, 16'h00a6,
        16'h00c8, 16'h01f4, 16'h0258, 16'h03e8, 16'h07d0, 16'h0fa0, 16'h1f40,
        16'h2710, 16'h4e20, 16'h9c40, 16'h9c40};

    // 250 MHz clock
    always #2 sys_clk_in = ~sys_clk_in;

    ahb_host host (.sys_clk_in(sys_clk_in), .hready_in(hready), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
        .hsize_out(hsize), .hwdata_out(hwdata));

    rate_ref_config DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .ref_below_thresh_in(ref_below), .clock_ext_sel_out(cext),
        .single_shot_out(sshot), .rate_code_out(code), .rate_dsps_out(dsps),
        .rate_reserved_out(rres), .ext_ref_monitor_enable_out(mon_en),
        .ref_fields_out(ref_fields), .ext_ref_low_flag_out(low_flag));

    // Compare and count; mismatches reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Flag only moves after the three-stage synchroniser has settled
    task automatic ref_step(input logic lvl, input logic exp);
        @(posedge sys_clk_in);
        ref_below <= lvl;
        repeat (6) @(posedge sys_clk_in);
        #1;
        chk({31'h0, low_flag}, {31'h0, exp});
    endtask : ref_step

    // Watchdog: the tests need under two hundred cycles
    initial begin
        #20000;
        failures++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge sys_clk_in);
        resetn_in <= 1'h1;
        #1;
        chk({28'h0, hresp, cext, sshot, mon_en}, 32'h0);
        chk({12'h0, dsps, code}, 32'h00c84);
        chk({26'h0, ref_fields}, 32'h10);
        host.xfer(1'h0, RATE_A, 32'h0, q);
        chk(q, 32'h14);
        host.xfer(1'h0, REF_A, 32'h0, q);
        chk(q, 32'h10);
        // Every usable rate code, with clock and mode bits walked alongside
        for (int c = 0; c < 15; c++) begin
            cb = c[3:0];
            host.xfer(1'h1, RATE_A, {24'h0, 1'h0, cb[0], cb[1], 1'h1, cb}, q);
            #1;
            chk({12'h0, dsps, code}, {12'h0, RATES[c], cb});
            chk({29'h0, rres, cext, sshot}, {30'h0, cb[0], cb[1]});
            host.xfer(1'h0, RATE_A, 32'h0, q);
            chk(q, {24'h0, 1'h0, cb[0], cb[1], 1'h1, cb});
        end
        host.xfer(1'h1, REF_A, 32'h7f, q);
        #1;
        chk({25'h0, mon_en, ref_fields}, 32'h7f);
        host.xfer(1'h0, REF_A, 32'h0, q);
        chk(q, 32'h7f);
        ref_step(1'h1, 1'h1);
        host.xfer(1'h0, STAT_A, 32'h0, q);
        chk(q, 32'h1);
        host.xfer(1'h1, REF_A, 32'h3f, q);
        #1;
        chk({31'h0, low_flag}, 32'h0);
        host.xfer(1'h1, REF_A, 32'h40, q);
        ref_step(1'h1, 1'h1);
        ref_step(1'h0, 1'h0);
        // Unmapped place reads as zero
        host.xfer(1'h0, 32'h40, 32'h0, q);
        chk(q, 32'h0);
        // Reset in mid-run brings back the values after reset
        @(posedge sys_clk_in);
        resetn_in <= 1'h0;
        repeat (2) @(posedge sys_clk_in);
        resetn_in <= 1'h1;
        #1;
        chk({28'h0, hresp, cext, sshot, mon_en}, 32'h0);
        chk({12'h0, dsps, code}, 32'h00c84);
        chk({25'h0, low_flag, ref_fields}, 32'h10);
        host.xfer(1'h0, RATE_A, 32'h0, q);
        chk(q, 32'h14);
        host.xfer(1'h0, REF_A, 32'h0, q);
        chk(q, 32'h10);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
